/* rsc_buf2.v */
// Two-entry buffer for received characters.
// Assumes one clock; a word moves on each side when valid and ready meet.
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_buf2 (
  input wire sys_clk,
  input wire srst,
  input wire [`RSC_DATA_W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [`RSC_DATA_W-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire full,
  output wire empty
);
  reg [`RSC_DATA_W-1:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign full = (cnt_q == 2'h2);
  assign empty = (cnt_q == 2'h0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end

  // Storage needs no reset; occupancy guards every read.
  always @(posedge sys_clk) begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end
endmodule

/* rsc_checker.sv */
// Port-level assertions for rsc_top.
// Assumes one sys_clk domain with synchronous active-high srst.
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_checker (
  input wire sys_clk,
  input wire srst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_lock,
  input wire rec_half_tick,
  input wire training_ref_clock,
  input wire [`RSC_DATA_W-1:0] rx_parallel_out,
  input wire rx_iface_clock,
  input wire rx_iface_clock_n,
  input wire reclock_pwrdn_flag
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Only the tick of the source chosen by lock may move the outputs.
  wire tick = rx_lock ? rec_half_tick : training_ref_clock;
  a_clock_pair:
    assert property (rx_iface_clock_n == !rx_iface_clock)
    else $error("clock pair not complementary");
  a_clock_quiet:
    assert property (!tick |=> $stable(rx_iface_clock))
    else $error("clock moved without tick");
  a_data_on_tick:
    assert property (!$past(srst) && $changed(rx_parallel_out)
      |-> $past(tick)) else $error("data moved without tick");
  a_pwrdn_write:
    assert property (!$past(srst) && $changed(reclock_pwrdn_flag)
      |-> ##[0:2] s_axi_bvalid) else $error("flag moved without write");
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_rresp_hold:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rresp)) else $error("r dropped");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no bvalid");
  c_pwrdn: cover property ($rose(reclock_pwrdn_flag));
  c_clock: cover property ($rose(rx_iface_clock));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind rsc_top rsc_checker chk_u (.*);

/* rsc_defs.vh */
// Constants for the receive status and interface clock block.
// Assumes a 200 MHz sys_clk and an AXI4-Lite master with 32-bit data.
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

`define RSC_ADDR_W 4
`define RSC_CTRL_ADDR 4'h0
`define RSC_STAT_ADDR 4'h4

// Control register fields.
`define RSC_CTRL_ST_LSB 0
`define RSC_CTRL_ST_MSB 1
`define RSC_CTRL_RATE 2
`define RSC_CTRL_OE1 3
`define RSC_CTRL_OE2 4
`define RSC_CTRL_RST 32'h0000_0018

// Status register fields.
`define RSC_STAT_PWRDN 0
`define RSC_STAT_ST 1
`define RSC_STAT_LOCK 2
`define RSC_STAT_FULL 3
`define RSC_STAT_EMPTY 4

`define RSC_ST_ACTIVE 2'h2
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2

`define RSC_DATA_W 10

`endif

/* rsc_host.sv */
// Host model that latches each word on the interface clock edge marking it.
// Assumes the bench tells it the rate and self-test setting in force.
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_host (
  input wire rx_iface_clock,
  input wire half_rate,
  input wire selftest_on,
  input wire [`RSC_DATA_W-1:0] rx_parallel_out,
  output reg [`RSC_DATA_W-1:0] host_word
);
  initial host_word = 10'h000;
  // Sampling 1 ns late keeps clear of the update made at the same edge.
  // The status flag is never looked at here; self-test keeps only the two code bits.
  always @(rx_iface_clock) begin
    if (rx_iface_clock || half_rate) begin
      #1;
      host_word = rx_parallel_out & (selftest_on ? 10'h003 : 10'h3FF);
    end
  end
endmodule

/* rsc_top.v */
// Receive status, reclocker power-down flag and receive interface clock.
// Assumes half-character tick pulses from the recovered data path and from
// the training reference, both synchronous to sys_clk, and an AXI4-Lite
// master that keeps one write and one read outstanding at most.
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_top (
  input wire sys_clk,
  input wire srst,
  input wire [`RSC_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`RSC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_lock,
  input wire rec_half_tick,
  input wire training_ref_clock,
  input wire [`RSC_DATA_W-1:0] rx_char_data,
  input wire rx_char_valid,
  output wire rx_char_ready,
  input wire selftest_in_flag,
  input wire [1:0] selftest_in_code,
  output reg [`RSC_DATA_W-1:0] rx_parallel_out,
  output reg selftest_status_flag,
  output reg rx_iface_clock,
  output wire rx_iface_clock_n,
  output wire reclock_pwrdn_flag
);
  reg [31:0] ctrl_q;
  reg [`RSC_ADDR_W-1:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg mid_q;
  reg [31:0] rdata_d;
  wire [1:0] rx_selftest_ctrl;
  wire rx_clock_rate_sel;
  wire reclock_out_en_first;
  wire reclock_out_en_second;
  wire selftest_on;
  wire half_tick;
  wire char_start;
  wire [`RSC_DATA_W-1:0] buf_data;
  wire buf_valid;
  wire buf_full;
  wire buf_empty;
  wire wr_go;
  wire rd_go;
  wire [31:0] ctrl_d;
  genvar g;

  assign rx_selftest_ctrl = ctrl_q[`RSC_CTRL_ST_MSB:`RSC_CTRL_ST_LSB];
  assign rx_clock_rate_sel = ctrl_q[`RSC_CTRL_RATE];
  assign reclock_out_en_first = ctrl_q[`RSC_CTRL_OE1];
  assign reclock_out_en_second = ctrl_q[`RSC_CTRL_OE2];
  assign selftest_on = (rx_selftest_ctrl == `RSC_ST_ACTIVE);

  // Decoded straight from the enables, so it follows them with no clock.
  assign reclock_pwrdn_flag = !reclock_out_en_first &&
                              !reclock_out_en_second;

  // Unlocked, the training reference paces the clock so it never stops;
  // locked, the recovered data ticks alone set it.
  assign half_tick = rx_lock ? rec_half_tick
                             : training_ref_clock;
  assign char_start = half_tick && mid_q;

  // The buffer absorbs a character while the output register waits for
  // the next character boundary, so outside self-test the source sees stalls, not losses.
  rsc_buf2 u_buf (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_data(rx_char_data),
    .in_valid(rx_char_valid),
    .in_ready(rx_char_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(char_start),
    .full(buf_full),
    .empty(buf_empty)
  );

  assign rx_iface_clock_n = ~rx_iface_clock;

  always @(posedge sys_clk) begin
    if (srst) begin
      mid_q <= 1'b0;
      rx_iface_clock <= 1'b0;
    end else if (half_tick) begin
      mid_q <= ~mid_q;
      // Full rate toggles every half character and rises at its start;
      // half rate toggles once per character.
      if (!rx_clock_rate_sel)
        rx_iface_clock <= mid_q;
      else if (mid_q)
        rx_iface_clock <= ~rx_iface_clock;
    end
  end

  // Data move only at the character start, which is the true rising edge
  // at full rate and each edge at half rate.
  always @(posedge sys_clk) begin
    if (srst) begin
      rx_parallel_out <= {`RSC_DATA_W{1'b0}};
      selftest_status_flag <= 1'b0;
    end else if (char_start) begin
      // The buffer still drains during self-test, so the character source
      // is never held off by a test.
      if (selftest_on) begin
        rx_parallel_out[`RSC_DATA_W-1:2] <= {(`RSC_DATA_W-2){1'b0}};
        rx_parallel_out[1:0] <= selftest_in_code;
        selftest_status_flag <= selftest_in_flag;
      end else begin
        if (buf_valid)
          rx_parallel_out <= buf_data;
        selftest_status_flag <= 1'b0;
      end
    end
  end

  // Write channel: address and data taken in either order, answer after both.
  // Neither half is offered while a response waits, so a second write
  // cannot overtake the one still being answered.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  // Each byte lane of the control word follows its own strobe, so a
  // partial write leaves the other lanes as they were.
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign ctrl_d[g*8 +: 8] = wstrb_q[g] ? wdata_q[g*8 +: 8]
                                           : ctrl_q[g*8 +: 8];
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (srst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {`RSC_ADDR_W{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RSC_RESP_OKAY;
      ctrl_q <= `RSC_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == `RSC_CTRL_ADDR) begin
          s_axi_bresp <= `RSC_RESP_OKAY;
          ctrl_q <= ctrl_d;
        end else if (awaddr_q == `RSC_STAT_ADDR) begin
          s_axi_bresp <= `RSC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `RSC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after the address.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always @* begin
    rdata_d = 32'h0000_0000;
    if (s_axi_araddr == `RSC_CTRL_ADDR) begin
      rdata_d[4:0] = ctrl_q[4:0];
    end else if (s_axi_araddr == `RSC_STAT_ADDR) begin
      rdata_d[`RSC_STAT_PWRDN] = reclock_pwrdn_flag;
      rdata_d[`RSC_STAT_ST] = selftest_status_flag;
      rdata_d[`RSC_STAT_LOCK] = rx_lock;
      rdata_d[`RSC_STAT_FULL] = buf_full;
      rdata_d[`RSC_STAT_EMPTY] = buf_empty;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RSC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      if (s_axi_araddr == `RSC_CTRL_ADDR || s_axi_araddr == `RSC_STAT_ADDR)
        s_axi_rresp <= `RSC_RESP_OKAY;
      else
        s_axi_rresp <= `RSC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* test_rsc_top.sv */
// Bench for rsc_top with the host model and the port checker.
// Assumes the design files, rsc_host and rsc_checker are compiled first.
`timescale 1ns/100ps
`include "rsc_defs.vh"
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_rsc_top;
  reg sys_clk = 1'h0, srst = 1'h1, half = 1'h0, st = 1'h0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  reg [31:0] s_axi_wdata = 32'h0, rd;
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, rx_lock = 1'h0;
  reg rec_half_tick = 1'h0, training_ref_clock = 1'h0, c;
  reg rx_char_valid = 1'h0, selftest_in_flag = 1'h0;
  reg [9:0] rx_char_data = 10'h0;
  reg [1:0] selftest_in_code = 2'h0, rr, br;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, rx_char_ready, selftest_status_flag, rx_iface_clock;
  wire rx_iface_clock_n, reclock_pwrdn_flag;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [9:0] rx_parallel_out, host_word;
  int fail_count = 0, checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  rsc_top dut_u (.*);
  rsc_host host_u (.rx_iface_clock(rx_iface_clock), .half_rate(half),
    .selftest_on(st), .rx_parallel_out(rx_parallel_out),
    .host_word(host_word));
  task automatic axw(input [3:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic axr(input [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge sys_clk);
  endtask
  // A pulse on the recovered tick when r is 1, else on the training tick.
  task automatic tick(input int k, input r);
    repeat (k) begin
      rec_half_tick <= r;
      training_ref_clock <= !r;
      @(posedge sys_clk);
      rec_half_tick <= 1'h0;
      training_ref_clock <= 1'h0;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
  task automatic push(input [9:0] d);
    rx_char_data <= d;
    rx_char_valid <= 1'h1;
    do
      @(posedge sys_clk);
    while (rx_char_ready !== 1'h1);
    rx_char_valid <= 1'h0;
    @(posedge sys_clk);
  endtask
  task t_regs;
    axr(4'h0);
    `CK("ctrl", `RSC_CTRL_RST, rd)
    axr(4'hC);
    `CK("bad_addr", `RSC_RESP_SLVERR, rr)
    axw(4'hC, 32'h0);
    `CK("wr_bad", `RSC_RESP_SLVERR, br)
    axw(4'h4, 32'h0);
    `CK("wr_stat", `RSC_RESP_OKAY, br)
    `CK("stat_ro", 1'h0, reclock_pwrdn_flag)
    s_axi_wstrb <= 4'hE;
    axw(4'h0, 32'h0);
    `CK("lane_keep", 1'h0, reclock_pwrdn_flag)
    s_axi_wstrb <= 4'hF;
    axw(4'h0, 32'h0);
    `CK("wr_okay", `RSC_RESP_OKAY, br)
    `CK("both_off", 1'h1, reclock_pwrdn_flag)
    axr(4'h4);
    `CK("stat_pd", 1'h1, rd[`RSC_STAT_PWRDN])
    axw(4'h0, 32'h8);
    `CK("first_on", 1'h0, reclock_pwrdn_flag)
    axw(4'h0, 32'h10);
    `CK("second_on", 1'h0, reclock_pwrdn_flag)
  endtask
  task t_stream;
    axw(4'h0, 32'h18);
    push(10'h2A5);
    push(10'h15A);
    @(posedge sys_clk);
    `CK("full", 1'h0, rx_char_ready)
    tick(2, 1'h1);
    `CK("unlocked", 10'h0, rx_parallel_out)
    tick(2, 1'h0);
    `CK("word_a", 10'h2A5, rx_parallel_out)
    `CK("clk_up", 1'h1, rx_iface_clock)
    `CK("clk_n", 1'h0, rx_iface_clock_n)
    `CK("host_a", 10'h2A5, host_word)
    rx_lock <= 1'h1;
    tick(2, 1'h0);
    `CK("locked", 10'h2A5, rx_parallel_out)
    tick(1, 1'h1);
    `CK("clk_mid", 1'h0, rx_iface_clock)
    tick(1, 1'h1);
    `CK("word_b", 10'h15A, rx_parallel_out)
    axr(4'h4);
    `CK("empty", 1'h1, rd[`RSC_STAT_EMPTY])
  endtask
  task t_selftest;
    axw(4'h0, 32'h1E);
    half <= 1'h1;
    st <= 1'h1;
    selftest_in_code <= 2'h1;
    selftest_in_flag <= 1'h1;
    push(10'h3FC);
    c = rx_iface_clock;
    tick(2, 1'h1);
    `CK("half_tgl", !c, rx_iface_clock)
    `CK("st_data", 10'h001, rx_parallel_out)
    `CK("st_flag", 1'h1, selftest_status_flag)
    `CK("host_st", 10'h001, host_word)
    tick(1, 1'h1);
    `CK("half_mid", !c, rx_iface_clock)
  endtask
  task t_reset;
    srst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    `CK("rst_data", 10'h000, rx_parallel_out)
    `CK("rst_flag", 1'h0, selftest_status_flag)
    `CK("rst_clk", 1'h0, rx_iface_clock)
    `CK("rst_clk_n", 1'h1, rx_iface_clock_n)
    axr(4'h0);
    `CK("rst_ctrl", `RSC_CTRL_RST, rd)
  endtask
  task finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    t_regs;
    t_stream;
    t_selftest;
    t_reset;
    finish_test;
  end
endmodule
